// ### rtl/spfo_regs.svh
// Constants of the serial page flash link and of the host controller
// Assumes inclusion by bare name from the two ends and the bench
`ifndef SPFO_REGS_SVH
`define SPFO_REGS_SVH

// ----------------------------------------------------------------
// Command opcodes seen on the serial link
// ----------------------------------------------------------------
`define SPFO_OP_LATCH_SET 8'h06
`define SPFO_OP_REWRITE 8'h0a
`define SPFO_OP_PROGRAM 8'h02
`define SPFO_OP_DEEP 8'hb9
`define SPFO_OP_WAKE 8'hab
`define SPFO_OP_RDSR 8'h05
`define SPFO_OP_WRSR 8'h01
`define SPFO_OP_READ 8'h03

// ----------------------------------------------------------------
// Status byte fields and array geometry
// ----------------------------------------------------------------
`define SPFO_ST_BUSY 0
`define SPFO_ST_LATCH 1
`define SPFO_ST_GUARD_LO 2
`define SPFO_ST_GUARD_HI 4
`define SPFO_MEM_BYTES 524288
`define SPFO_TOP_SECTOR 3'h7

// ----------------------------------------------------------------
// Host controller register offsets, fields and reset values
// ----------------------------------------------------------------
`define SPFO_A_CTRL 12'h000
`define SPFO_A_DATA 12'h004
`define SPFO_A_STAT 12'h008
`define SPFO_C_MODE3 0
`define SPFO_C_HOLD_CS 1
`define SPFO_C_RST 2
`define SPFO_C_PROT 3
`define SPFO_CTRL_RST 32'h0000000c

// ----------------------------------------------------------------
// Timing: serial clock half period and its cycle count
// ----------------------------------------------------------------
`define SPFO_PCLK_NS 4
`define SPFO_SCK_HALF_NS 32
`define SPFO_HALF_CYC \
	((`SPFO_SCK_HALF_NS + `SPFO_PCLK_NS - 1) / `SPFO_PCLK_NS)

`endif

// ### rtl/spfo_pkg.sv
// Types shared by both ends of the serial page flash link
// Assumes spfo_regs.svh is on the include path
package spfo_pkg;

	// ------------------------------------------------------------
	// Device internal cycle phases
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CY_IDLE = 2'b00,
		CY_FILL = 2'b01,
		CY_ERASE = 2'b10,
		CY_PROG = 2'b11
	} spfo_cycle_e;

	// ------------------------------------------------------------
	// Host byte engine states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LO = 2'b01,
		H_HI = 2'b10,
		H_TAIL = 2'b11
	} spfo_host_e;

	// Whole device state
	typedef struct packed {
		logic [1:0] sck_s; // Clock synchroniser
		logic [1:0] cs_s; // Select synchroniser
		logic [1:0] d_s; // Data in synchroniser
		logic [1:0] rst_s; // Reset pin synchroniser
		logic [1:0] prot_s; // Protect pin synchroniser
		logic sck_p; // Clock of last cycle
		logic arm; // Select seen high since reset
		logic in; // Selected period running
		logic ld; // Output byte load pending
		logic [2:0] bitc; // Bits in current byte
		logic [2:0] bcnt; // Bytes seen, saturating at 5
		logic [7:0] sh; // Input shift
		logic [7:0] op; // Command byte
		logic [7:0] odata; // Output shift
		logic [23:0] addr; // Address
		logic miso; // Output bit
		logic miso_oe; // Output drive
		logic write_latch_flag; // Write latch flag
		logic deep; // Deep power-down
		logic rewrite; // Cycle is a rewrite
		logic [2:0] bp; // Block guard bits
		spfo_cycle_e cyc; // Internal cycle phase
		logic [7:0] idx; // Byte within page
		logic [10:0] pg; // Page of cycle
		logic [255:0] bvalid; // Buffer bytes loaded
		logic act; // Active power
		logic bsy; // Cycle busy copy
	} spfo_dev_s;

	// Whole host state
	typedef struct packed {
		logic [1:0] miso_s; // Data in synchroniser
		spfo_host_e st; // Byte engine state
		logic [3:0] cnt; // Half period counter
		logic [2:0] bits; // Bits sent
		logic [7:0] tx; // Output shift
		logic [7:0] rx; // Input shift
		logic sck; // Serial clock
		logic cs_n; // Chip select
		logic mosi; // Serial data out
		logic cpol; // Mode three selected
		logic keep; // Hold select after byte
		logic hold_rst; // Drive reset pin low
		logic prot; // Protect pin level
		logic pready; // Bus ready
		logic pslverr; // Bus error
		logic [31:0] prdata; // Bus read data
	} spfo_host_s;

endpackage

// ### rtl/spfo_link_if.sv
// Serial link between the flash device and its host controller
// Assumes the bench joins both ends to one instance
`timescale 1ns/1ps
interface spfo_link_if;
	logic sck; // Serial clock
	logic cs_n; // Chip select, active low
	logic mosi; // Host to device data
	logic miso; // Device output bit
	logic miso_oe; // Device drives output
	logic rst_n; // Device reset pin, active low
	logic prot_n; // Write protect or top lock pin
	logic miso_line; // Resolved line, pulled high

	// Undriven line reads as the pull-up
	assign miso_line = miso_oe ? miso : 1'b1;

	modport dev(input sck, cs_n, mosi, rst_n, prot_n,
		output miso, miso_oe);
	modport host(output sck, cs_n, mosi, rst_n, prot_n,
		input miso_line);
endinterface

// ### rtl/spfo_flash_dev.sv
// Serial page flash device: link decoding, page buffer, internal cycle
// Assumes pclk far faster than the serial clock; pins are asynchronous
`timescale 1ns/1ps
`include "spfo_regs.svh"

module spfo_flash_dev import spfo_pkg::*; #(
	parameter bit NEW_VARIANT = 1'b1 // 1 protect pin, 0 top lock pin
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	spfo_link_if.dev link, // Serial pins
	output logic power_active, // Active power mode
	output logic power_deep, // Deep power-down mode
	output logic cycle_busy // Internal cycle running
);

	// ------------------------------------------------------------
	// Storage and state
	// ------------------------------------------------------------
	localparam spfo_dev_s RST_V = '{cs_s: 2'b11, cyc: CY_IDLE, default: '0};

	logic [7:0] mem [0:`SPFO_MEM_BYTES-1]; // Flash array
	logic [7:0] pbuf [0:255]; // Page buffer
	spfo_dev_s q; // Current state
	spfo_dev_s d; // Next state
	spfo_dev_s nx; // State under pin reset
	logic mem_we; // Array write strobe
	logic [18:0] mem_wa; // Array write address
	logic [7:0] mem_wd; // Array write data
	logic buf_we; // Buffer write strobe
	logic [7:0] buf_wa; // Buffer write address
	logic [7:0] buf_wd; // Buffer write data
	logic [7:0] cyc_rd; // Array byte under the cycle
	logic [7:0] out_rd; // Array byte for read out
	logic sel; // Chip selected
	logic rise; // Serial clock rising
	logic fall; // Serial clock falling
	logic [7:0] byte_v; // Byte completed at this rise
	logic exec; // Deselect may execute

	// Protection of a sector by guard bits and lock pin
	function automatic logic spfo_locked(input logic [2:0] bp,
		input logic [2:0] sect, input logic lock_low);
		logic [3:0] first;
		first = 4'h8 - (4'h1 << (bp - 3'h1));
		if (!NEW_VARIANT && lock_low && sect == `SPFO_TOP_SECTOR)
			return 1'b1;
		if (bp == 3'h0)
			return 1'b0;
		if (bp >= 3'h4)
			return 1'b1;
		return {1'b0, sect} >= first;
	endfunction

	// Erased array at power-up
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
	end

	assign cyc_rd = mem[{q.pg, q.idx}];
	assign out_rd = mem[q.addr[18:0]];
	assign sel = !q.cs_s[1];
	assign rise = q.sck_s[1] && !q.sck_p;
	assign fall = !q.sck_s[1] && q.sck_p;
	assign byte_v = {q.sh[6:0], q.d_s[1]};
	assign exec = q.bitc == 3'h0 && q.cyc == CY_IDLE;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		nx = RST_V;
		mem_we = 1'b0;
		mem_wa = {q.pg, q.idx};
		mem_wd = 8'hff;
		buf_we = 1'b0;
		buf_wa = q.idx;
		buf_wd = cyc_rd;
		// Pin synchronisers
		d.sck_s = {q.sck_s[0], link.sck};
		d.cs_s = {q.cs_s[0], link.cs_n};
		d.d_s = {q.d_s[0], link.mosi};
		d.rst_s = {q.rst_s[0], link.rst_n};
		d.prot_s = {q.prot_s[0], link.prot_n};
		d.sck_p = q.sck_s[1];
		d.arm = q.arm || !sel;
		// Internal cycle, one byte per clock
		unique case (q.cyc)
			CY_IDLE: begin
			end
			CY_FILL: begin
				// Untouched bytes come from the page
				buf_we = !q.bvalid[q.idx];
				d.bvalid[q.idx] = 1'b1;
				d.idx = q.idx + 8'h1;
				if (&q.idx)
					d.cyc = CY_ERASE;
			end
			CY_ERASE: begin
				mem_we = 1'b1;
				d.idx = q.idx + 8'h1;
				if (&q.idx)
					d.cyc = CY_PROG;
			end
			CY_PROG: begin
				// Only ones turn to zeros here
				mem_we = 1'b1;
				mem_wd = cyc_rd &
					(q.bvalid[q.idx] ? pbuf[q.idx] : 8'hff);
				d.idx = q.idx + 8'h1;
				if (&q.idx) begin
					d.cyc = CY_IDLE;
					d.write_latch_flag = 1'b0;
					d.bvalid = '0;
				end
			end
		endcase
		// Output byte load, one cycle after the byte
		if (q.ld) begin
			d.ld = 1'b0;
			if (q.op == `SPFO_OP_RDSR) begin
				d.odata = '0;
				d.odata[`SPFO_ST_BUSY] = q.cyc != CY_IDLE;
				d.odata[`SPFO_ST_LATCH] = q.write_latch_flag;
				d.odata[`SPFO_ST_GUARD_HI:`SPFO_ST_GUARD_LO] = q.bp;
			end else begin
				d.odata = out_rd;
				d.addr = q.addr + 24'h1;
			end
		end
		// Start of a selected period
		if (sel && !q.in && q.arm) begin
			d.in = 1'b1;
			d.bitc = 3'h0;
			d.bcnt = 3'h0;
			d.odata = 8'h00;
			d.miso_oe = 1'b1;
			// Bytes of a refused sequence must not leak into the next
			if (q.cyc == CY_IDLE)
				d.bvalid = '0;
		end
		// Input bit on the rising edge
		if (sel && q.in && rise) begin
			d.sh = byte_v;
			d.bitc = q.bitc + 3'h1;
			if (q.bitc == 3'h7) begin
				if (q.bcnt != 3'h5)
					d.bcnt = q.bcnt + 3'h1;
				if (q.bcnt == 3'h0) begin
					d.op = byte_v;
					d.ld = !q.deep && byte_v == `SPFO_OP_RDSR;
				end else if (q.bcnt < 3'h4) begin
					d.addr = {q.addr[15:0], byte_v};
					d.ld = !q.deep && q.bcnt == 3'h3 &&
						q.op == `SPFO_OP_READ;
				end else if (q.op == `SPFO_OP_REWRITE ||
					q.op == `SPFO_OP_PROGRAM) begin
					if (!q.deep && q.cyc == CY_IDLE) begin
						buf_we = 1'b1;
						buf_wa = q.addr[7:0];
						buf_wd = byte_v;
						d.bvalid[q.addr[7:0]] = 1'b1;
						d.addr[7:0] = q.addr[7:0] + 8'h1;
					end
				end else begin
					d.ld = !q.deep && (q.op == `SPFO_OP_READ ||
						q.op == `SPFO_OP_RDSR);
				end
			end
		end
		// Output bit from the falling edge
		if (sel && q.in && fall) begin
			d.miso = q.odata[7];
			d.odata = {q.odata[6:0], 1'b0};
		end
		// End of a selected period
		if (!sel && q.in) begin
			d.in = 1'b0;
			d.miso_oe = 1'b0;
			d.ld = 1'b0;
			if (q.deep) begin
				// Only wake is heard in deep sleep
				if (exec && q.bcnt == 3'h1 && q.op == `SPFO_OP_WAKE)
					d.deep = 1'b0;
			end else if (exec) begin
				case (q.op)
					`SPFO_OP_LATCH_SET: begin
						if (q.bcnt == 3'h1)
							d.write_latch_flag = 1'b1;
					end
					`SPFO_OP_DEEP: begin
						if (q.bcnt == 3'h1)
							d.deep = 1'b1;
					end
					`SPFO_OP_WRSR: begin
						// Frozen while protect pin is low
						if (NEW_VARIANT && q.bcnt == 3'h2 && q.write_latch_flag) begin
							if (q.prot_s[1])
								d.bp = q.sh[`SPFO_ST_GUARD_HI:
									`SPFO_ST_GUARD_LO];
							d.write_latch_flag = 1'b0;
						end
					end
					`SPFO_OP_REWRITE, `SPFO_OP_PROGRAM: begin
						if (q.bcnt == 3'h5 && q.write_latch_flag &&
							!spfo_locked(q.bp, q.addr[18:16],
							!q.prot_s[1])) begin
							d.pg = q.addr[18:8];
							d.idx = 8'h0;
							d.rewrite = q.op == `SPFO_OP_REWRITE;
							d.cyc = q.op == `SPFO_OP_REWRITE ?
								CY_FILL : CY_PROG;
						end
					end
					default: begin
						// Unknown or read commands end here
					end
				endcase
			end
		end
		d.act = sel || d.cyc != CY_IDLE;
		d.bsy = d.cyc != CY_IDLE;
		// Reset pin: all but pins and guard bits cleared
		if (!q.rst_s[1]) begin
			nx.sck_s = d.sck_s;
			nx.cs_s = d.cs_s;
			nx.d_s = d.d_s;
			nx.rst_s = d.rst_s;
			nx.prot_s = d.prot_s;
			nx.sck_p = d.sck_p;
			nx.bp = q.bp;
			d = nx;
			mem_we = 1'b0;
			buf_we = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			q <= RST_V;
		else
			q <= d;
	end

	// Array and buffer writes
	always_ff @(posedge pclk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
		if (buf_we)
			pbuf[buf_wa] <= buf_wd;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.miso = q.miso;
	assign link.miso_oe = q.miso_oe;
	assign power_active = q.act;
	assign power_deep = q.deep;
	assign cycle_busy = q.bsy;

endmodule // spfo_flash_dev

// ### rtl/spfo_spi_host.sv
// Host controller: APB registers driving the serial link byte by byte
// Assumes APB from the same pclk; the device output is asynchronous
`timescale 1ns/1ps
`include "spfo_regs.svh"

module spfo_spi_host import spfo_pkg::*; (
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	spfo_link_if.host link // Serial pins
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam logic [3:0] HALF_M1 = 4'(`SPFO_HALF_CYC - 1);
	localparam spfo_host_s RST_V = '{cs_n: 1'b1,
		hold_rst: 1'(`SPFO_CTRL_RST >> `SPFO_C_RST),
		prot: 1'(`SPFO_CTRL_RST >> `SPFO_C_PROT), st: H_IDLE,
		default: '0};

	spfo_host_s q; // Current state
	spfo_host_s d; // Next state
	logic wr; // Write takes effect
	logic half; // Half period elapsed

	assign wr = psel && penable && pwrite && q.pready;
	assign half = q.cnt == HALF_M1;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.miso_s = {q.miso_s[0], link.miso_line};
		d.pready = 1'b0;
		// Setup cycle: decode and prepare the answer
		if (psel && !penable) begin
			d.pready = 1'b1;
			d.pslverr = 1'b0;
			d.prdata = '0;
			case (paddr)
				`SPFO_A_CTRL: begin
					d.prdata[`SPFO_C_MODE3] = q.cpol;
					d.prdata[`SPFO_C_HOLD_CS] = q.keep;
					d.prdata[`SPFO_C_RST] = q.hold_rst;
					d.prdata[`SPFO_C_PROT] = q.prot;
				end
				`SPFO_A_DATA: d.prdata[7:0] = q.rx;
				`SPFO_A_STAT: d.prdata[0] = q.st != H_IDLE;
				default: d.pslverr = 1'b1;
			endcase
		end
		// Control write
		if (wr && paddr == `SPFO_A_CTRL) begin
			d.cpol = pwdata[`SPFO_C_MODE3];
			d.keep = pwdata[`SPFO_C_HOLD_CS];
			d.hold_rst = pwdata[`SPFO_C_RST];
			d.prot = pwdata[`SPFO_C_PROT];
			if (q.st == H_IDLE && q.cs_n)
				d.sck = pwdata[`SPFO_C_MODE3];
		end
		// Byte engine
		unique case (q.st)
			H_IDLE: begin
				// Data write starts a byte; ignored while busy
				if (wr && paddr == `SPFO_A_DATA) begin
					d.tx = pwdata[7:0];
					d.mosi = pwdata[7];
					d.cs_n = 1'b0;
					d.sck = 1'b0;
					d.cnt = 4'h0;
					d.bits = 3'h0;
					d.st = H_LO;
				end
			end
			H_LO: begin
				d.cnt = q.cnt + 4'h1;
				if (half) begin
					d.cnt = 4'h0;
					d.sck = 1'b1;
					d.rx = {q.rx[6:0], q.miso_s[1]};
					d.st = H_HI;
				end
			end
			H_HI: begin
				d.cnt = q.cnt + 4'h1;
				if (half) begin
					d.cnt = 4'h0;
					d.bits = q.bits + 3'h1;
					if (q.bits == 3'h7) begin
						d.sck = q.cpol;
						d.st = H_TAIL;
					end else begin
						d.sck = 1'b0;
						d.tx = {q.tx[6:0], 1'b0};
						d.mosi = q.tx[6];
						d.st = H_LO;
					end
				end
			end
			H_TAIL: begin
				d.cnt = q.cnt + 4'h1;
				if (half) begin
					d.cnt = 4'h0;
					d.cs_n = !q.keep;
					d.st = H_IDLE;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			q <= RST_V;
		else
			q <= d;
	end

	// Outputs
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign link.sck = q.sck;
	assign link.cs_n = q.cs_n;
	assign link.mosi = q.mosi;
	assign link.rst_n = !q.hold_rst;
	assign link.prot_n = q.prot;

endmodule // spfo_spi_host

// ### test/spfo_link_chk.sv
// Checker on the serial link between host controller and flash device
// Assumes the bench wires link signals and device status outputs in
`timescale 1ns/1ps
module spfo_link_chk (
	input wire logic pclk, // System clock
	input wire logic presetn, // Reset, active low
	input wire logic sck, // Serial clock
	input wire logic cs_n, // Chip select, active low
	input wire logic mosi, // Host data out
	input wire logic miso, // Device data bit
	input wire logic miso_oe, // Device drive enable
	input wire logic rst_n, // Device reset pin, active low
	input wire logic power_active, // Active power mode
	input wire logic power_deep, // Deep power-down
	input wire logic cycle_busy // Internal cycle running
);
	// ------------------------------------------------------------
	// Length of the current internal cycle
	// ------------------------------------------------------------
	logic [10:0] run_q; // Busy cycles so far
	logic [10:0] run_d; // Next count
	// Count while busy, clear when idle
	always_comb begin
		run_d = cycle_busy ? run_q + 11'd1 : 11'd0;
	end
	// Register the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 11'd0;
		end else begin
			run_q <= run_d;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_oe_idle; cs_n [*5] |-> !miso_oe; endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("output driven while deselected");
	property p_oe_rst; !rst_n [*5] |-> !miso_oe; endproperty
	a_oe_rst: assert property (p_oe_rst)
		else $error("output driven while reset pin low");
	property p_oe_sel;
		$fell(cs_n) && rst_n && !power_deep |-> ##[1:6] miso_oe;
	endproperty
	a_oe_sel: assert property (p_oe_sel)
		else $error("output not driven after select");
	property p_act_sel; (!cs_n) [*5] |-> power_active; endproperty
	a_act_sel: assert property (p_act_sel)
		else $error("not active while selected");
	property p_act_busy; cycle_busy && $past(cycle_busy) |-> power_active;
	endproperty
	a_act_busy: assert property (p_act_busy)
		else $error("not active during internal cycle");
	property p_standby; (cs_n && !cycle_busy) [*6] |-> !power_active;
	endproperty
	a_standby: assert property (p_standby)
		else $error("active while deselected and idle");
	property p_run_len;
		$fell(cycle_busy) && run_q > 11'd300 |-> run_q inside {[760:780]};
	endproperty
	a_run_len: assert property (p_run_len)
		else $error("rewrite cycle of wrong length");
	property p_deep_sel; (!cs_n) [*6] |-> $stable(power_deep); endproperty
	a_deep_sel: assert property (p_deep_sel)
		else $error("power-down changed within a selection");
	property p_deep_idle; power_deep |-> !cycle_busy; endproperty
	a_deep_idle: assert property (p_deep_idle)
		else $error("cycle running in power-down");
	property p_miso_fall;
		!cs_n && miso_oe && $past(miso_oe) && $changed(miso)
			|-> !sck && !$past(sck, 2);
	endproperty
	a_miso_fall: assert property (p_miso_fall)
		else $error("device output changed outside low clock phase");
	property p_mosi_hi; !cs_n && sck && $past(sck) |-> $stable(mosi);
	endproperty
	a_mosi_hi: assert property (p_mosi_hi)
		else $error("host data changed while clock high");
	c_rewrite: cover property ($fell(cycle_busy) && run_q > 11'd300);
	c_deep: cover property ($rose(power_deep));
	c_idle_hi: cover property (cs_n && sck);
	c_drive: cover property ($rose(miso_oe));
endmodule // spfo_link_chk

// ### test/tb_spi_page_flash_operations.sv
// Bench joining host controller and flash device over one link
// Assumes rtl/ on the include path; software side reached over APB
`timescale 1ns/1ps
`include "spfo_regs.svh"
module tb_spi_page_flash_operations;
	logic pclk, presetn, psel, penable, pwrite; // Clock, reset, bus
	logic [11:0] paddr; // Bus address
	logic [31:0] pwdata, prdata, rd; // Bus data, last read
	logic pready, pslverr, er; // Bus answer, last error
	logic power_active, power_deep, cycle_busy, busy_old; // Device status
	logic mode3, prot; // Wanted link mode and protect pin
	logic [7:0] s; // Byte read back
	int errors, n_checks; // Mismatches, comparisons

	spfo_link_if link(); // Shared serial link
	spfo_spi_host i_spfo_spi_host(.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.link(link.host));
	spfo_flash_dev #(.NEW_VARIANT(1'b1)) i_spfo_flash_dev(.pclk,
		.presetn, .link(link.dev), .power_active, .power_deep,
		.cycle_busy);
	// Older variant listening on the same pins, output left unread
	spfo_link_if link_old();
	assign link_old.sck = link.sck;
	assign link_old.cs_n = link.cs_n;
	assign link_old.mosi = link.mosi;
	assign link_old.rst_n = link.rst_n;
	assign link_old.prot_n = link.prot_n;
	spfo_flash_dev #(.NEW_VARIANT(1'b0)) i_spfo_flash_dev_old(.pclk,
		.presetn, .link(link_old.dev), .power_active(), .power_deep(),
		.cycle_busy(busy_old));
	spfo_link_chk i_spfo_link_chk(.pclk, .presetn, .sck(link.sck),
		.cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
		.miso_oe(link.miso_oe), .rst_n(link.rst_n), .power_active,
		.power_deep, .cycle_busy);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	// One bus transfer; answer lands in rd and er
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// One byte on the link; hold keeps the device selected
	task automatic send(input logic [7:0] b, input logic hold);
		apb(1'b1, `SPFO_A_CTRL, {28'h0, prot, 1'b0, hold, mode3});
		apb(1'b1, `SPFO_A_DATA, {24'h0, b});
		do apb(1'b0, `SPFO_A_STAT, 32'h0); while (rd[0] !== 1'b0);
	endtask
	// Whole command, select released after the last byte
	task automatic cmd(input logic [7:0] q[$]);
		foreach (q[i]) send(q[i], i < q.size() - 1);
	endtask
	// Command whose last received byte goes to s
	task automatic ask(input logic [7:0] q[$]);
		cmd(q);
		apb(1'b0, `SPFO_A_DATA, 32'h0);
		s = rd[7:0];
	endtask
	// Array byte at a into s
	task automatic peek(input logic [23:0] a);
		ask('{`SPFO_OP_READ, a[23:16], a[15:8], a[7:0], 8'h00});
	endtask
	// Latch set, modify command, poll until the cycle ends
	task automatic modify(input logic [7:0] q[$]);
		cmd('{`SPFO_OP_LATCH_SET});
		cmd(q);
		do ask('{`SPFO_OP_RDSR, 8'h00}); while (s[0] !== 1'b0);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset values, unmapped place, device reset pin release
	task automatic t_reset();
		apb(1'b0, `SPFO_A_CTRL, 32'h0);
		check(rd, `SPFO_CTRL_RST);
		check({link.rst_n, link.miso_oe}, 2'b00);
		apb(1'b0, 12'h00c, 32'h0);
		check(er, 1'b1);
		apb(1'b1, `SPFO_A_CTRL, 32'h00000008);
	endtask
	// Refused rewrite, then a rewrite wrapping inside its page
	task automatic t_rewrite();
		logic [7:0] a[6] = '{8'hfe, 8'hff, 8'h00, 8'h01, 8'h02, 8'h10};
		logic [7:0] d[6] = '{8'h12, 8'h34, 8'h56, 8'h77, 8'hff, 8'hff};
		cmd('{`SPFO_OP_REWRITE, 8'h00, 8'h00, 8'h10, 8'haa});
		peek(24'h000010);
		check(s, 8'hff);
		cmd('{`SPFO_OP_LATCH_SET});
		ask('{`SPFO_OP_RDSR, 8'h00});
		check(s, 8'h02);
		cmd('{`SPFO_OP_REWRITE, 8'h00, 8'h00, 8'hfe, 8'h12, 8'h34,
			8'h56});
		ask('{`SPFO_OP_RDSR, 8'h00});
		check(s[0], 1'b1);
		check({cycle_busy, power_active}, 2'b11);
		do ask('{`SPFO_OP_RDSR, 8'h00}); while (s[0] !== 1'b0);
		check(s, 8'h00);
		modify('{`SPFO_OP_REWRITE, 8'h00, 8'h00, 8'h01, 8'h77});
		for (int i = 0; i < 6; i++) begin
			peek({16'h0000, a[i]});
			check(s, d[i]);
		end
		check(link.sck, 1'b0);
	endtask
	// Program only clears bits, rewrite sets them again
	task automatic t_program();
		modify('{`SPFO_OP_PROGRAM, 8'h00, 8'h00, 8'hfe, 8'h0f});
		peek(24'h0000fe);
		check(s, 8'h02);
		modify('{`SPFO_OP_REWRITE, 8'h00, 8'h00, 8'hfe, 8'hf0});
		peek(24'h0000fe);
		check(s, 8'hf0);
	endtask
	// Same traffic with the clock idling high
	task automatic t_mode3();
		mode3 = 1'b1;
		modify('{`SPFO_OP_REWRITE, 8'h00, 8'h00, 8'h40, 8'hc3});
		peek(24'h000040);
		check(s, 8'hc3);
		check(link.sck, 1'b1);
		mode3 = 1'b0;
	endtask
	// Power-down ignores latch set until woken
	task automatic t_deep();
		cmd('{`SPFO_OP_DEEP});
		for (int n = 0; n < 16 && power_deep !== 1'b1; n++) @(posedge pclk);
		check(power_deep, 1'b1);
		cmd('{`SPFO_OP_LATCH_SET});
		cmd('{`SPFO_OP_WAKE});
		for (int n = 0; n < 16 && power_deep !== 1'b0; n++) @(posedge pclk);
		check(power_deep, 1'b0);
		ask('{`SPFO_OP_RDSR, 8'h00});
		check(s, 8'h00);
	endtask
	// Guard bits protect the array; protect pin low freezes them
	task automatic t_guard();
		modify('{`SPFO_OP_WRSR, 8'h1c});
		modify('{`SPFO_OP_REWRITE, 8'h07, 8'h00, 8'h00, 8'h5a});
		peek(24'h070000);
		check(s, 8'hff);
		prot = 1'b0;
		modify('{`SPFO_OP_WRSR, 8'h00});
		check(s[4:2], 3'h7);
		prot = 1'b1;
		modify('{`SPFO_OP_WRSR, 8'h00});
		check(s[4:2], 3'h0);
	endtask
	// Older variant: lock pin low guards only the top sector
	task automatic t_lock();
		for (int k = 0; k < 2; k++) begin
			prot = k[0];
			cmd('{`SPFO_OP_LATCH_SET});
			cmd('{`SPFO_OP_REWRITE, 8'h07, 8'h00, 8'h00, 8'h5a});
			repeat (8) @(posedge pclk);
			check({cycle_busy, busy_old}, {1'b1, k[0]});
			do ask('{`SPFO_OP_RDSR, 8'h00}); while (s[0] !== 1'b0);
		end
	endtask

	// ------------------------------------------------------------
	// Clock, sequence, watchdog and verdict
	// ------------------------------------------------------------
	// Verdict and end of run
	task automatic give_verdict();
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Free-running system clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Reset, then the scenarios in turn
	initial begin
		{presetn, psel, penable, pwrite, mode3, prot} = 6'b000001;
		paddr = 12'h0;
		pwdata = 32'h0;
		errors = 0;
		n_checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_rewrite();
		t_program();
		t_mode3();
		t_deep();
		t_guard();
		t_lock();
		give_verdict();
	end
	// Cut a hang short
	initial begin
		repeat (90000) @(posedge pclk);
		errors++;
		give_verdict();
	end
endmodule // tb_spi_page_flash_operations
